// File: design/ibl_pkg.sv
// Package of constants and types for the individual block lock controller.
package ibl_pkg;

    // ************************************************************
    // Command opcodes
    // ************************************************************
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_PROTECT_SELECT = 8'hA5;
    localparam logic [7:0] OP_BLOCK_LOCK     = 8'h36;
    localparam logic [7:0] OP_BLOCK_UNLOCK   = 8'h39;
    localparam logic [7:0] OP_GANG_LOCK      = 8'h7E;
    localparam logic [7:0] OP_GANG_UNLOCK    = 8'h98;

    // ************************************************************
    // Address layout and lock memory geometry
    // ************************************************************
    localparam int ADDR_W      = 24;
    localparam int BLK_W       = 8;
    localparam int SEC_W       = 4;
    localparam int SEC_PER_BLK = 16;
    localparam int BLK_HI      = 23;
    localparam int BLK_LO      = 16;
    localparam int SEC_HI      = 15;
    localparam int SEC_LO      = 12;
    localparam logic [BLK_W-1:0] FIRST_BLOCK = 8'h00;
    localparam logic [BLK_W-1:0] LAST_BLOCK  = 8'hFF;

    // ************************************************************
    // Frame counting and security register layout
    // ************************************************************
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
    localparam logic [2:0] BYTES_OPCODE   = 3'h1;
    localparam logic [2:0] BYTES_ADDR_CMD = 3'h4;
    localparam int         SEL_BIT        = 7;
    localparam logic [7:0] SECURITY_RESET = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_MERGE = 2'b10,
        ST_SWEEP = 2'b11
    } ibl_state_t;

    typedef struct packed {
        logic              lock;
        logic [ADDR_W-1:0] addr;
    } ibl_cmd_t;

    typedef struct packed {
        logic done;
        logic prot;
    } ibl_check_t;

endpackage

// File: design/ibl_lock_mem.sv
// Lock bit memory: one word of sector lock bits per 64 KB block, two read ports.
`timescale 1ns/10ps
`default_nettype none
module ibl_lock_mem
    import ibl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   wr_en,
    input  wire logic [BLK_W-1:0]       wr_addr,
    input  wire logic [SEC_PER_BLK-1:0] wr_data,
    input  wire logic [BLK_W-1:0]       rd_a_addr,
    output var  logic [SEC_PER_BLK-1:0] rd_a_data,
    input  wire logic [BLK_W-1:0]       rd_b_addr,
    output var  logic [SEC_PER_BLK-1:0] rd_b_data
);

    logic [SEC_PER_BLK-1:0] mem [0:(1<<BLK_W)-1];

    // Array has no reset; the owner sweeps it after reset before any read matters.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Both read ports are registered, so data lags the address by one cycle.
    always_ff @(posedge clk) begin
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule
`default_nettype wire

// File: design/ibl_lock_ctrl.sv
// Individual block lock controller: serial command decode, lock state and protection check.
`timescale 1ns/10ps
`default_nettype none
module ibl_lock_ctrl
    import ibl_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              CS_N,
    input  wire logic              SCLK,
    input  wire logic              SI,
    input  wire logic              WP_N,
    input  wire logic              SELECT_STRAP,
    input  wire logic              CHECK_REQ,
    input  wire logic [ADDR_W-1:0] CHECK_ADDR,
    output var  logic              CHECK_DONE,
    output var  logic              CHECK_PROTECTED,
    output var  logic [7:0]        SECURITY_REG,
    output var  logic              SELECT_SET_PULSE,
    output var  logic              WRITE_ENABLE_LATCH,
    output var  logic              BUSY
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic is_single(input logic [7:0] op);
        return (op == OP_BLOCK_LOCK) || (op == OP_BLOCK_UNLOCK);
    endfunction

    function automatic logic is_gang(input logic [7:0] op);
        return (op == OP_GANG_LOCK) || (op == OP_GANG_UNLOCK);
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       sclk_prev;
    logic       cs_prev;
    logic       cs_n_s;
    logic       sclk_s;
    logic       si_s;
    logic       wp_n_s;

    // Two flops per pin; the first stage feeds only the second.
    // Reset loads the idle pin levels, so no false serial clock edge follows reset.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pin_meta <= 4'h9;
            pin_sync <= 4'h9;
        end else begin
            pin_meta <= {CS_N, SCLK, SI, WP_N};
            pin_sync <= pin_meta;
        end
    end

    assign cs_n_s = pin_sync[3];
    assign sclk_s = pin_sync[2];
    assign si_s   = pin_sync[1];
    assign wp_n_s = pin_sync[0];

    // Edge history for the serial clock and chip select.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_prev <= sclk_s;
            cs_prev   <= cs_n_s;
        end
    end

    logic sclk_rise;
    logic frame_end;
    assign sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
    assign frame_end = cs_n_s & ~cs_prev;

    // ************************************************************
    // Serial shifter
    // ************************************************************
    logic [6:0]        shift;
    logic [2:0]        bit_cnt;
    logic [2:0]        byte_cnt;
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic              aligned;

    // Mode 0 framing: sample SI on each rising serial clock edge.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            shift    <= 7'h00;
            bit_cnt  <= 3'h0;
            byte_cnt <= 3'h0;
            opcode   <= 8'h00;
            addr     <= 24'h000000;
        end else if (cs_n_s) begin
            bit_cnt  <= 3'h0;
            byte_cnt <= (frame_end) ? byte_cnt : 3'h0;
        end else if (sclk_rise) begin
            shift   <= {shift[5:0], si_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
                if (byte_cnt != BYTE_CNT_MAX) begin
                    byte_cnt <= byte_cnt + 3'h1;
                end
                if (byte_cnt == 3'h0) begin
                    opcode <= {shift, si_s};
                end else begin
                    addr <= {addr[15:0], shift, si_s};
                end
            end
        end
    end

    // A frame counts only if chip select rose exactly on a byte boundary.
    assign aligned = (bit_cnt == 3'h0);

    // ************************************************************
    // Command qualification
    // ************************************************************
    logic       select;
    logic       strap_pending;
    logic       init_pending;
    logic       wel;
    ibl_state_t state;
    logic       idle_ok;
    logic       exec_select;
    logic       exec_single;
    logic       exec_gang;

    assign idle_ok     = (state == ST_IDLE) & ~init_pending;
    assign exec_select = frame_end & aligned & (byte_cnt == BYTES_OPCODE)
                         & (opcode == OP_PROTECT_SELECT);
    // Single commands need select, the latch and exactly four whole bytes.
    assign exec_single = frame_end & aligned & (byte_cnt == BYTES_ADDR_CMD)
                         & is_single(opcode) & select & wel & idle_ok;
    assign exec_gang   = frame_end & aligned & (byte_cnt == BYTES_OPCODE)
                         & is_gang(opcode) & select & wel & idle_ok;

    // ************************************************************
    // Protect select bit
    // ************************************************************
    // The stored non-volatile value is taken one cycle after reset release.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            select        <= 1'b0;
            strap_pending <= 1'b1;
        end else if (strap_pending) begin
            select        <= SELECT_STRAP;
            strap_pending <= 1'b0;
        end else if (exec_select) begin
            select <= 1'b1;
        end
    end

    // One pulse asks the non-volatile store to keep the select bit.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SELECT_SET_PULSE <= 1'b0;
        end else begin
            SELECT_SET_PULSE <= exec_select & ~strap_pending & ~select;
        end
    end

    // ************************************************************
    // Write-enable latch
    // ************************************************************
    // Any lock-changing frame consumes the latch, even a rejected one.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wel <= 1'b0;
        end else if (frame_end & (is_single(opcode) | is_gang(opcode))) begin
            wel <= 1'b0;
        end else if (frame_end & aligned & (byte_cnt == BYTES_OPCODE)
                     & (opcode == OP_WRITE_ENABLE)) begin
            wel <= 1'b1;
        end
    end

    // ************************************************************
    // Lock update sequencer
    // ************************************************************
    ibl_cmd_t               cmd;
    logic [BLK_W-1:0]       sweep_cnt;
    logic                   fill;
    logic                   mem_wr;
    logic [BLK_W-1:0]       mem_wr_addr;
    logic [SEC_PER_BLK-1:0] mem_wr_data;
    logic [SEC_PER_BLK-1:0] rd_a_data;
    logic [SEC_PER_BLK-1:0] rd_b_data;
    logic [BLK_W-1:0]       cmd_blk;
    logic [SEC_W-1:0]       cmd_sec;
    logic                   sector_region;

    assign cmd_blk       = cmd.addr[BLK_HI:BLK_LO];
    assign cmd_sec       = cmd.addr[SEC_HI:SEC_LO];
    // Only the first and last blocks are split into separately lockable sectors.
    assign sector_region = (cmd_blk == FIRST_BLOCK) || (cmd_blk == LAST_BLOCK);

    // Gang commands and the power-on fill walk every block, one per cycle.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state        <= ST_IDLE;
            init_pending <= 1'b1;
            sweep_cnt    <= 8'h00;
            fill         <= 1'b0;
            cmd          <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (init_pending & ~strap_pending) begin
                        init_pending <= 1'b0;
                        fill         <= select;
                        sweep_cnt    <= FIRST_BLOCK;
                        state        <= ST_SWEEP;
                    end else if (exec_gang) begin
                        fill      <= (opcode == OP_GANG_LOCK);
                        sweep_cnt <= FIRST_BLOCK;
                        state     <= ST_SWEEP;
                    end else if (exec_single) begin
                        cmd.lock <= (opcode == OP_BLOCK_LOCK);
                        cmd.addr <= addr;
                        state    <= ST_FETCH;
                    end
                end
                ST_FETCH: state <= ST_MERGE;
                ST_MERGE: state <= ST_IDLE;
                ST_SWEEP: begin
                    sweep_cnt <= sweep_cnt + 8'h01;
                    if (sweep_cnt == LAST_BLOCK) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Sector edits read, patch one bit, and write back the block's word.
    always_comb begin
        mem_wr      = 1'b0;
        mem_wr_addr = cmd_blk;
        mem_wr_data = {SEC_PER_BLK{cmd.lock}};
        if (state == ST_SWEEP) begin
            mem_wr      = 1'b1;
            mem_wr_addr = sweep_cnt;
            mem_wr_data = {SEC_PER_BLK{fill}};
        end else if (state == ST_MERGE) begin
            mem_wr = 1'b1;
            if (sector_region) begin
                mem_wr_data          = rd_a_data;
                mem_wr_data[cmd_sec] = cmd.lock;
            end
        end
    end

    ibl_lock_mem u_mem (
        .clk       (CLK_SYS),
        .wr_en     (mem_wr),
        .wr_addr   (mem_wr_addr),
        .wr_data   (mem_wr_data),
        .rd_a_addr (cmd_blk),
        .rd_a_data (rd_a_data),
        .rd_b_addr (CHECK_ADDR[BLK_HI:BLK_LO]),
        .rd_b_data (rd_b_data)
    );

    // ************************************************************
    // Program and erase protection check
    // ************************************************************
    logic             chk_vld;
    logic [SEC_W-1:0] chk_sec;
    ibl_check_t       chk;
    logic             chk_lock;

    // Lock bit of the checked sector, read one cycle after the request.
    assign chk_lock = rd_b_data[chk_sec];

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            chk_vld <= 1'b0;
            chk_sec <= 4'h0;
        end else begin
            chk_vld <= CHECK_REQ;
            chk_sec <= CHECK_ADDR[SEC_HI:SEC_LO];
        end
    end

    // Outside select mode CHECK_PROTECTED stays low though CHECK_DONE still pulses; legacy bits decide there.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            chk <= '0;
        end else begin
            chk.done <= chk_vld;
            chk.prot <= chk_vld & select & (~wp_n_s | chk_lock);
        end
    end

    assign CHECK_DONE         = chk.done;
    assign CHECK_PROTECTED    = chk.prot;
    assign SECURITY_REG       = SECURITY_RESET | ({7'h00, select} << SEL_BIT);
    assign WRITE_ENABLE_LATCH = wel;
    assign BUSY               = ~idle_ok;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_select_sticky: assert property (select |=> select)
        else $error("select bit was cleared");
    a_select_sets: assert property (exec_select && !strap_pending |=> SECURITY_REG[SEL_BIT])
        else $error("select command did not set bit 7");
    a_single_needs_wel: assert property (state == ST_FETCH |-> $past(wel) && select)
        else $error("single command ran without latch or select");
    a_wel_consumed: assert property (frame_end && is_single(opcode) |=> !wel)
        else $error("write enable latch survived single command");
    a_unaligned_drop: assert property (frame_end && !aligned && idle_ok |=> state == ST_IDLE)
        else $error("unaligned frame started an update");
    a_wp_protects: assert property (chk_vld && select && !wp_n_s |=> CHECK_PROTECTED)
        else $error("low write protect did not protect");
    a_lock_gates: assert property (
        chk_vld && select && wp_n_s |=> CHECK_PROTECTED == $past(chk_lock))
        else $error("check result differs from lock bit");
    a_merge_bit: assert property (
        state == ST_FETCH |=> mem_wr && mem_wr_data[cmd_sec] == cmd.lock ##1 state == ST_IDLE)
        else $error("single update wrote wrong bit");
    a_sweep_len: assert property (
        $rose(state == ST_SWEEP) |-> ##255 state == ST_SWEEP ##1 state != ST_SWEEP)
        else $error("sweep length is not 256 cycles");

    c_select: cover property (exec_select && !select);
    c_single: cover property (state == ST_MERGE && sector_region);
    c_gang: cover property (exec_gang);
    c_wp_block: cover property (chk_vld && select && !wp_n_s);

endmodule
`default_nettype wire

// File: test/ibl_host_model.sv
// Behavioural serial host that frames commands for the lock controller.
`timescale 1ns/10ps
`default_nettype none
module ibl_host_model (
    input  wire logic CLK_SYS,
    output var  logic CS_N,
    output var  logic SCLK,
    output var  logic SI
);
    // ********************
    // Frame driver
    // ********************
    // Idle state: deselected, serial clock parked low for mode 0.
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SI   = 1'b0;
    end

    // Shifts nbits MSB first; each serial clock level lasts four system clocks so
    // the synchroniser inside the device never misses an edge.
    task automatic xfer(input logic [39:0] data, input int nbits);
        @(negedge CLK_SYS);
        CS_N = 1'b0;
        repeat (4) @(negedge CLK_SYS);
        for (int i = 0; i < nbits; i++) begin
            SI = data[39-i];
            repeat (4) @(negedge CLK_SYS);
            SCLK = 1'b1;
            repeat (4) @(negedge CLK_SYS);
            SCLK = 1'b0;
        end
        repeat (4) @(negedge CLK_SYS);
        CS_N = 1'b1;
        // A released line shows the inverse of its last bit, never a stale copy.
        SI = ~SI;
        repeat (10) @(negedge CLK_SYS);
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking testbench for the individual block lock controller.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ibl_pkg::*;
;
    // ********************
    // Signals and instances
    // ********************
    logic              clk;
    logic              rst;
    logic              cs_n;
    logic              sclk;
    logic              si;
    logic              wp_n;
    logic              strap;
    logic              check_req;
    logic [ADDR_W-1:0] check_addr;
    logic              check_done;
    logic              check_prot;
    logic [7:0]        sec_reg;
    logic              sel_pulse;
    logic              wel;
    logic              busy;
    int                miscompares;
    int                n_compared;
    int                n_pulse;

    // Free-running 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ibl_lock_ctrl DUT (
        .CLK_SYS            (clk),
        .RST                (rst),
        .CS_N               (cs_n),
        .SCLK               (sclk),
        .SI                 (si),
        .WP_N               (wp_n),
        .SELECT_STRAP       (strap),
        .CHECK_REQ          (check_req),
        .CHECK_ADDR         (check_addr),
        .CHECK_DONE         (check_done),
        .CHECK_PROTECTED    (check_prot),
        .SECURITY_REG       (sec_reg),
        .SELECT_SET_PULSE   (sel_pulse),
        .WRITE_ENABLE_LATCH (wel),
        .BUSY               (busy)
    );

    ibl_host_model host (
        .CLK_SYS (clk),
        .CS_N    (cs_n),
        .SCLK    (sclk),
        .SI      (si)
    );

    // Counts select pulses; only the first setting of select may produce one.
    // Sampled at the falling edge, where the registered pulse has settled.
    always @(negedge clk) begin
        if (sel_pulse === 1'b1) begin
            n_pulse++;
        end
    end

    // ********************
    // Shared tasks
    // ********************
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // A hang in a sweep ends the run rather than stalling it.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            miscompares++;
            $display("ERROR busy expected 0 seen %b", busy);
            final_report();
        end
    endtask

    // The answer stands for one cycle only: high between the first and second
    // edges after the request edge, so it is looked at on the falling edge between.
    task automatic check_prot_at(input logic [ADDR_W-1:0] a, input logic exp);
        @(negedge clk);
        check_req = 1'b1;
        check_addr = a;
        @(negedge clk);
        check_req = 1'b0;
        @(negedge clk);
        check_bit("check_done", 1'b1, check_done);
        check_bit("check_protected", exp, check_prot);
    endtask

    task automatic do_reset(input logic s);
        strap = s;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        check_bit("busy_in_reset", 1'b1, busy);
        check_byte("security_in_reset", 8'h00, sec_reg);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        wait_idle();
    endtask

    task automatic cmd(input logic [7:0] op);
        host.xfer({op, 32'h0}, 8);
    endtask

    task automatic addr_cmd(input logic [7:0] op, input logic [ADDR_W-1:0] a);
        host.xfer({op, a, 8'h00}, 32);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_legacy();
        do_reset(1'b0);
        check_byte("security_reg", 8'h00, sec_reg);
        check_prot_at(24'h120000, 1'b0);
        cmd(OP_WRITE_ENABLE);
        check_bit("latch_after_write_enable_cmd", 1'b1, wel);
        addr_cmd(OP_BLOCK_LOCK, 24'h120000);
        check_bit("latch_after_lock", 1'b0, wel);
    endtask

    task automatic t_select();
        cmd(OP_PROTECT_SELECT);
        check_byte("security_reg", 8'h80, sec_reg);
        check_prot_at(24'h120000, 1'b0);
        cmd(OP_PROTECT_SELECT);
        check_byte("security_again", 8'h80, sec_reg);
        check_byte("select_pulses", 8'h01, 8'(n_pulse));
        wp_n = 1'b0;
        repeat (4) @(negedge clk);
        check_prot_at(24'h120000, 1'b1);
        wp_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic t_single();
        addr_cmd(OP_BLOCK_LOCK, 24'h120000);
        check_prot_at(24'h120000, 1'b0);
        cmd(OP_WRITE_ENABLE);
        addr_cmd(OP_BLOCK_LOCK, 24'h123456);
        check_bit("latch_after_lock", 1'b0, wel);
        check_prot_at(24'h12FFFF, 1'b1);
        check_prot_at(24'h130000, 1'b0);
        check_prot_at(24'h11FFFF, 1'b0);
        cmd(OP_WRITE_ENABLE);
        addr_cmd(OP_BLOCK_LOCK, 24'h005000);
        check_prot_at(24'h005ABC, 1'b1);
        check_prot_at(24'h006000, 1'b0);
        check_prot_at(24'h004FFF, 1'b0);
        cmd(OP_WRITE_ENABLE);
        addr_cmd(OP_BLOCK_UNLOCK, 24'h120000);
        check_prot_at(24'h12FFFF, 1'b0);
        check_prot_at(24'h005ABC, 1'b1);
    endtask

    // Unaligned end, short frame and long frame must all leave the lock bits alone.
    task automatic t_reject();
        int len [3] = '{33, 24, 40};
        foreach (len[i]) begin
            cmd(OP_WRITE_ENABLE);
            host.xfer({OP_BLOCK_LOCK, 24'h400000, 8'h00}, len[i]);
            check_bit("latch_after_reject", 1'b0, wel);
            check_prot_at(24'h400000, 1'b0);
        end
    endtask

    task automatic t_gang();
        logic [ADDR_W-1:0] probe [3] = '{24'h000000, 24'h5A1234, 24'hFFF000};
        cmd(OP_GANG_LOCK);
        wait_idle();
        check_prot_at(24'h400000, 1'b0);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_GANG_LOCK);
        wait_idle();
        foreach (probe[i]) check_prot_at(probe[i], 1'b1);
        cmd(OP_WRITE_ENABLE);
        cmd(OP_GANG_UNLOCK);
        wait_idle();
        foreach (probe[i]) check_prot_at(probe[i], 1'b0);
    endtask

    task automatic t_poweron();
        do_reset(1'b1);
        check_byte("security_reg", 8'h80, sec_reg);
        check_byte("pulses_after_strap", 8'h01, 8'(n_pulse));
        check_prot_at(24'h770000, 1'b1);
        check_prot_at(24'hFFF000, 1'b1);
        cmd(OP_WRITE_ENABLE);
        addr_cmd(OP_BLOCK_UNLOCK, 24'h770000);
        check_prot_at(24'h77ABCD, 1'b0);
        check_prot_at(24'h780000, 1'b1);
    endtask

    // Main sequence: every input is given a value at time zero.
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        strap = 1'b0;
        check_req = 1'b0;
        check_addr = 24'h000000;
        miscompares = 0;
        n_compared = 0;
        n_pulse = 0;
        t_legacy();
        t_select();
        t_single();
        t_reject();
        t_gang();
        t_poweron();
        final_report();
    end
endmodule
`default_nettype wire
